// [pkg/ecd_pkg.sv]
// ecd_pkg: constants, register map and state type of the eight-channel dma controller
// assumes a word-indexed register port: index = {channel, register} below 0x40
// Operation
// - eight identical channels, own register sets
// - move ram-to-peripheral or peripheral-to-ram
// - own transfer bus, cpu never stalled
// - ram pointer post-increment or held
// - peripheral supplies ram address when indirect
// - byte or word per transfer
// - fixed priority among simultaneous requests
// - start by software force or peripheral request
// - one-shot stops, continuous restarts block
// - ping-pong swaps start address per block
// - seven-bit request number selects trigger source
// - request 13 is converter, address 0x0300
// - request 2 compare, addresses 0x0182/0x0180
// - request 10 serial port, address 0x0248
// - interrupt at block end or half block
// - registers 16 bits, count 10 bits
// - start reads give live pointer, writes store
// - pad and count registers are plain storage; control loses enable at stop, request reads the force flag
// - shared register of collision flags per channel
// - shared register: active channel, ping-pong state
// - flags live in external interrupt controller
// - block length is count plus one
// - force starts one transfer, hardware clears
// - mode field: ping-pong and one-shot bits
// - direction bit one reads ram, writes peripheral
`default_nettype none
package ecd_pkg;
    localparam int          NCH          = 8;
    localparam logic [2:0]  OFS_CTL      = 3'h0;
    localparam logic [2:0]  OFS_REQ      = 3'h1;
    localparam logic [2:0]  OFS_STA      = 3'h2;
    localparam logic [2:0]  OFS_STB      = 3'h3;
    localparam logic [2:0]  OFS_PAD      = 3'h4;
    localparam logic [2:0]  OFS_CNT      = 3'h5;
    localparam logic [6:0]  OFS_COLL     = 7'h40;
    localparam logic [6:0]  OFS_PPS      = 7'h41;
    localparam int          BIT_CHEN     = 15;
    localparam int          BIT_SIZE     = 14;
    localparam int          BIT_DIR      = 13;
    localparam int          BIT_HALF     = 12;
    localparam int          BIT_NULLW    = 11;
    localparam int          AMODE_LSB    = 4;
    localparam int          MODE_LSB     = 0;
    localparam int          BIT_FORCE    = 15;
    localparam logic [15:0] CTL_MASK     = 16'hF833;
    localparam logic [1:0]  AM_INC       = 2'h0;
    localparam logic [1:0]  AM_HOLD      = 2'h1;
    localparam logic [15:0] RST_REG      = 16'h0000;
    localparam logic [6:0]  RST_SEL      = 7'h00;
    localparam logic [9:0]  RST_CNT      = 10'h000;
    localparam logic [3:0]  RST_IDLE_CH  = 4'hF;
    localparam logic [6:0]  RQ_ADC       = 7'h0D;
    localparam logic [15:0] PA_ADC       = 16'h0300;
    localparam logic [6:0]  RQ_OC1       = 7'h02;
    localparam logic [15:0] PA_OC1_DATA  = 16'h0182;
    localparam logic [15:0] PA_OC1_SEC   = 16'h0180;
    localparam logic [6:0]  RQ_SPI1      = 7'h0A;
    localparam logic [15:0] PA_SPI1      = 16'h0248;

    typedef enum logic [1:0] {ST_IDLE, ST_RD, ST_CAP, ST_WR} ecd_state_t;

    // next ram pointer: one byte or one word further
    function automatic logic [15:0] ecd_step(input logic [15:0] p, input logic is_byte);
        return p + (is_byte ? 16'h0001 : 16'h0002);
    endfunction : ecd_step
endpackage : ecd_pkg
`default_nettype wire

// [sim/ecd_controller_tb.sv]
// ecd_controller_tb: register, forced transfer and arbitration checks
// assumes ecd_far_model answers both read ports
`default_nettype none
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin n_mismatch++; $display("[ERR] %s exp %h got %h", n, e, g); end end
module ecd_controller_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_clock, i_sys_rst, i_clk_en, i_wr, i_rd, i_cpu_ram_we, i_cpu_per_we;
    logic o_ram_we, o_ram_re, o_per_we, o_per_re;
    logic [6:0] i_addr;
    logic [15:0] i_wdata, i_periph_ram_addr, i_cpu_ram_addr, i_cpu_per_addr, i_ram_rdata, i_per_rdata;
    logic [15:0] o_rdata, o_ram_addr, o_ram_wdata, o_per_addr, o_per_wdata;
    logic [1:0] o_ram_be, o_per_be;
    logic [127:0] i_irq_req;
    logic [7:0] o_ch_irq;
    int n_mismatch, total_checks;
    ecd_controller ecd_controller_i (.i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_clk_en(i_clk_en),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_irq_req(i_irq_req),
        .i_periph_ram_addr(i_periph_ram_addr), .o_ram_addr(o_ram_addr), .o_ram_wdata(o_ram_wdata),
        .o_ram_be(o_ram_be), .o_ram_we(o_ram_we), .o_ram_re(o_ram_re), .i_ram_rdata(i_ram_rdata),
        .o_per_addr(o_per_addr), .o_per_wdata(o_per_wdata), .o_per_be(o_per_be), .o_per_we(o_per_we),
        .o_per_re(o_per_re), .i_per_rdata(i_per_rdata), .i_cpu_ram_we(i_cpu_ram_we),
        .i_cpu_ram_addr(i_cpu_ram_addr), .i_cpu_per_we(i_cpu_per_we), .i_cpu_per_addr(i_cpu_per_addr),
        .o_ch_irq(o_ch_irq));
    ecd_far_model ecd_far_model_i (.i_clock(i_clock), .i_ram_re(o_ram_re), .i_ram_addr(o_ram_addr),
        .i_per_re(o_per_re), .i_per_addr(o_per_addr), .o_ram_rdata(i_ram_rdata), .o_per_rdata(i_per_rdata));
    // 200 MHz
    initial begin
        i_clock = 1'b0;
        forever #2.5 i_clock = ~i_clock;
    end
    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : summarize
    // strobes drop a cycle later, so back-to-back calls leave a gap
    task automatic wr(input logic [6:0] a, input logic [15:0] d);
        @(posedge i_clock) begin i_wr <= 1'b1; i_addr <= a; i_wdata <= d; end
        @(posedge i_clock) i_wr <= 1'b0;
    endtask : wr
    task automatic rdc(input logic [6:0] a, input logic [15:0] e, input string n);
        @(posedge i_clock) begin i_rd <= 1'b1; i_addr <= a; end
        @(posedge i_clock) i_rd <= 1'b0;
        #1 `CHK(n, e, o_rdata)
    endtask : rdc
    // bounded wait for a write on either port (ram=1) or a peripheral read
    task automatic wt(input bit ram);
        int n;
        n = 0;
        do begin @(posedge i_clock); #1 n++; end
        while (!(ram ? (o_ram_we === 1'b1 || o_per_we === 1'b1) : o_per_re === 1'b1) && n < 40);
        if (n >= 40) begin n_mismatch++; summarize(); end
    endtask : wt
    task automatic t_regs();
        wr(7'h08, 16'h7FFF);
        rdc(7'h08, 16'h7833, "ctl");
        wr(7'h0D, 16'hFFFF);
        rdc(7'h0D, 16'h03FF, "cnt");
        wr(7'h0C, 16'hA55A);
        wr(7'h3C, 16'h1234);
        rdc(7'h0C, 16'hA55A, "pad");
        wr(7'h09, 16'hFFFF);
        rdc(7'h09, 16'h007F, "req");
        rdc(7'h41, 16'h0F00, "status");
        wr(7'h40, 16'hFFFF);
        rdc(7'h40, 16'h0000, "coll");
        rdc(7'h0E, 16'h0000, "unmapped");
    endtask : t_regs
    // cpu writes the target ram word during the dma write
    task automatic t_force();
        wr(7'h04, 16'h0248);
        wr(7'h02, 16'h0100);
        wr(7'h05, 16'h0000);
        wr(7'h00, 16'h8001);
        wr(7'h01, 16'h8000);
        wt(1'b0);
        `CHK("per_addr", 16'h0248, o_per_addr)
        @(posedge i_clock) begin i_cpu_ram_we <= 1'b1; i_cpu_ram_addr <= 16'h0100; end
        wt(1'b1);
        `CHK("ram_addr", 16'h0100, o_ram_addr)
        `CHK("ram_data", 16'h5848, o_ram_wdata)
        `CHK("ram_be", 2'h3, o_ram_be)
        `CHK("irq", 8'h01, o_ch_irq)
        @(posedge i_clock) i_cpu_ram_we <= 1'b0;
        rdc(7'h01, 16'h0000, "force");
        rdc(7'h00, 16'h0001, "oneshot");
        rdc(7'h02, 16'h0100, "pointer");
        rdc(7'h40, 16'h0001, "xcol");
        wr(7'h40, 16'h0000);
        rdc(7'h40, 16'h0000, "xclr");
    endtask : t_force
    task automatic t_arb();
        wr(7'h11, 16'h000D);
        wr(7'h14, 16'h0300);
        wr(7'h29, 16'h000A);
        wr(7'h2C, 16'h0248);
        wr(7'h10, 16'h8000);
        wr(7'h28, 16'h8020);
        @(posedge i_clock) begin
            i_irq_req         <= (128'h1 << 13) | (128'h1 << 10);
            i_periph_ram_addr <= 16'h0776;
        end
        @(posedge i_clock) i_irq_req <= '0;
        wt(1'b0);
        `CHK("first", 16'h0300, o_per_addr)
        wt(1'b0);
        `CHK("second", 16'h0248, o_per_addr)
        wt(1'b1);
        `CHK("indirect", 16'h0776, o_ram_addr)
        wr(7'h10, 16'h0000);
        wr(7'h28, 16'h0000);
    endtask : t_arb
    // byte lanes, held pointer, half-block irq, ping-pong side, clock enable freeze
    task automatic t_dir();
        wr(7'h1C, 16'h0249);
        wr(7'h1A, 16'h0201);
        wr(7'h1B, 16'h0411);
        wr(7'h1D, 16'h0001);
        wr(7'h18, 16'hF013);
        wr(7'h19, 16'h8000);
        wt(1'b1);
        `CHK("per_addr3", 16'h0249, o_per_addr)
        `CHK("per_data", 16'h3E00, o_per_wdata)
        `CHK("per_be", 2'h2, o_per_be)
        `CHK("half_irq", 8'h08, o_ch_irq)
        rdc(7'h1A, 16'h0201, "hold");
        @(posedge i_clock) begin i_cpu_per_we <= 1'b1; i_cpu_per_addr <= 16'h0249; end
        wr(7'h19, 16'h8000);
        wt(1'b1);
        `CHK("end_irq", 8'h00, o_ch_irq)
        @(posedge i_clock) i_cpu_per_we <= 1'b0;
        rdc(7'h40, 16'h0800, "pcol");
        rdc(7'h1A, 16'h0411, "pp_ptr");
        rdc(7'h41, 16'h0F08, "pp_side");
        rdc(7'h18, 16'hF013, "pp_run");
        @(posedge i_clock) i_clk_en <= 1'b0;
        wr(7'h1D, 16'h0155);
        @(posedge i_clock) i_clk_en <= 1'b1;
        rdc(7'h1D, 16'h0001, "frozen");
    endtask : t_dir
    initial begin
        {i_sys_rst, i_clk_en, i_wr, i_rd, i_cpu_ram_we, i_cpu_per_we} = 6'h30;
        {i_addr, i_wdata, i_irq_req} = '0;
        {i_periph_ram_addr, i_cpu_ram_addr, i_cpu_per_addr} = '0;
        repeat (3) @(posedge i_clock);
        i_sys_rst <= 1'b0;
        t_regs();
        t_force();
        t_arb();
        t_dir();
        summarize();
    end
endmodule : ecd_controller_tb
`default_nettype wire

// [sim/ecd_far_model.sv]
// ecd_far_model: dma ram and peripheral read responders
// assumes one-cycle registered read strobes from the controller
`default_nettype none
module ecd_far_model (
    input  wire logic        i_clock,
    input  wire logic        i_ram_re,
    input  wire logic [15:0] i_ram_addr,
    input  wire logic        i_per_re,
    input  wire logic [15:0] i_per_addr,
    output logic      [15:0] o_ram_rdata,
    output logic      [15:0] o_per_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] ram_r;
    logic [15:0] per_r;
    logic        rv_r;
    logic        pv_r;
    // data stands one cycle only; inverted after so a late sample shows
    always_ff @(posedge i_clock) begin
        rv_r <= i_ram_re;
        pv_r <= i_per_re;
        if (i_ram_re) ram_r <= 16'h3C00 ^ i_ram_addr;
        if (i_per_re) per_r <= 16'h5A00 ^ i_per_addr;
    end
    assign o_ram_rdata = rv_r ? ram_r : ~ram_r;
    assign o_per_rdata = pv_r ? per_r : ~per_r;
endmodule : ecd_far_model
`default_nettype wire

// [verilog/ecd_arbiter.sv]
// ecd_arbiter: fixed-priority pick among pending channels
// assumes requests already gated by channel enable; purely combinational
`default_nettype none
module ecd_arbiter (
    input  wire logic [7:0] i_req,
    output logic            o_valid,
    output logic      [2:0] o_idx
);
    // lowest index wins; scan from the top so the last hit is the lowest
    function automatic logic [2:0] first_set(input logic [7:0] v);
        logic [2:0] idx;
        idx = 3'h0;
        for (int i = 7; i >= 0; i--) begin
            if (v[i]) begin
                idx = 3'(i);
            end
        end
        return idx;
    endfunction : first_set

    assign o_valid = |i_req;
    assign o_idx   = first_set(i_req);
endmodule : ecd_arbiter
`default_nettype wire

// [verilog/ecd_controller.sv]
// ecd_controller: register file, per-channel state and the transfer engine
// assumes cpu, peripherals and dma ram on i_clock; both data reads answer one cycle later
`default_nettype none
module ecd_controller (
    input  wire logic         i_clock,
    input  wire logic         i_sys_rst,
    input  wire logic         i_clk_en,
    input  wire logic [6:0]   i_addr,
    input  wire logic [15:0]  i_wdata,
    input  wire logic         i_wr,
    input  wire logic         i_rd,
    output logic      [15:0]  o_rdata,
    input  wire logic [127:0] i_irq_req,
    input  wire logic [15:0]  i_periph_ram_addr,
    output logic      [15:0]  o_ram_addr,
    output logic      [15:0]  o_ram_wdata,
    output logic      [1:0]   o_ram_be,
    output logic              o_ram_we,
    output logic              o_ram_re,
    input  wire logic [15:0]  i_ram_rdata,
    output logic      [15:0]  o_per_addr,
    output logic      [15:0]  o_per_wdata,
    output logic      [1:0]   o_per_be,
    output logic              o_per_we,
    output logic              o_per_re,
    input  wire logic [15:0]  i_per_rdata,
    input  wire logic         i_cpu_ram_we,
    input  wire logic [15:0]  i_cpu_ram_addr,
    input  wire logic         i_cpu_per_we,
    input  wire logic [15:0]  i_cpu_per_addr,
    output logic      [7:0]   o_ch_irq
);
    // per-channel register sets, indexed by channel
    logic [15:0]         ctl_r   [ecd_pkg::NCH];
    logic [6:0]          sel_r   [ecd_pkg::NCH];
    logic [15:0]         sta_r   [ecd_pkg::NCH];
    logic [15:0]         stb_r   [ecd_pkg::NCH];
    logic [15:0]         pad_r   [ecd_pkg::NCH];
    logic [9:0]          cnt_r   [ecd_pkg::NCH];
    logic [15:0]         ptr_r   [ecd_pkg::NCH];
    logic [9:0]          done_r  [ecd_pkg::NCH];
    logic [7:0]          force_r;
    logic [7:0]          pend_r;
    logic [7:0]          pps_r;
    logic [7:0]          xcol_r;
    logic [7:0]          pcol_r;
    ecd_pkg::ecd_state_t state_r;
    logic [2:0]          cur_r;
    logic [15:0]         ea_r;
    logic [3:0]          act_r;

    // address decode
    logic        is_ch;
    logic [2:0]  ch_sel;
    logic [2:0]  reg_sel;
    logic        wr_coll;
    assign is_ch   = (i_addr[6] == 1'b0);
    assign ch_sel  = i_addr[5:3];
    assign reg_sel = i_addr[2:0];
    assign wr_coll = i_wr && (i_addr == ecd_pkg::OFS_COLL);

    function automatic logic hit(input logic [2:0] ch, input logic [2:0] ofs);
        return i_wr && is_ch && (ch_sel == ch) && (reg_sel == ofs);
    endfunction : hit

    // per-channel enable, trigger and force request
    logic [7:0] chen_v;
    logic [7:0] trig_v;
    logic [7:0] force_set;
    always_comb begin
        for (int c = 0; c < ecd_pkg::NCH; c++) begin
            chen_v[c]    = ctl_r[c][ecd_pkg::BIT_CHEN];
            force_set[c] = hit(3'(c), ecd_pkg::OFS_REQ) && i_wdata[ecd_pkg::BIT_FORCE] && chen_v[c];
            // any request number reaches any channel
            trig_v[c]    = (chen_v[c] && i_irq_req[sel_r[c]]) || force_set[c];
        end
    end

    // current channel view
    logic [15:0] cur_ctl;
    logic [9:0]  cur_cnt;
    logic [9:0]  cur_done;
    logic [1:0]  cur_am;
    logic [7:0]  cur_oh;
    logic        cur_pps;
    logic        pp_on;
    logic        dir;
    logic        is_last;
    logic        is_half;
    logic        irq_hit;
    logic        stop_now;
    logic        bk;
    assign cur_ctl  = ctl_r[cur_r];
    assign cur_cnt  = cnt_r[cur_r];
    assign cur_done = done_r[cur_r];
    assign cur_am   = cur_ctl[ecd_pkg::AMODE_LSB +: 2];
    assign cur_oh   = 8'h01 << cur_r;
    assign cur_pps  = pps_r[cur_r];
    assign pp_on    = cur_ctl[ecd_pkg::MODE_LSB + 1];
    assign dir      = cur_ctl[ecd_pkg::BIT_DIR];
    assign is_last  = (cur_done == cur_cnt);
    assign is_half  = (cur_done == {1'b0, cur_cnt[9:1]});
    assign irq_hit  = cur_ctl[ecd_pkg::BIT_HALF] ? is_half : is_last;
    // one-shot ping-pong runs one block from each buffer before stopping
    assign stop_now = is_last && cur_ctl[ecd_pkg::MODE_LSB] && !(pp_on && !cur_pps);
    assign bk       = i_clk_en && (state_r == ecd_pkg::ST_CAP);

    // arbitration only while the engine is idle
    logic [7:0]  arb_req;
    logic        g_valid;
    logic [2:0]  g_idx;
    logic        take;
    logic [7:0]  g_clr;
    logic [15:0] g_ctl;
    logic [15:0] g_ea;
    assign arb_req = pend_r & chen_v;
    assign take    = i_clk_en && (state_r == ecd_pkg::ST_IDLE) && g_valid;
    assign g_clr   = take ? (8'h01 << g_idx) : 8'h00;
    assign g_ctl   = ctl_r[g_idx];
    assign g_ea    = g_ctl[ecd_pkg::AMODE_LSB + 1] ? i_periph_ram_addr : ptr_r[g_idx];

    ecd_arbiter u_arb (
        .i_req   (arb_req),
        .o_valid (g_valid),
        .o_idx   (g_idx)
    );

    // lane steering of the captured word
    logic        src_hi;
    logic        dst_hi;
    logic [15:0] src_data;
    logic [15:0] ln_data;
    logic [1:0]  ln_be;
    assign src_hi   = dir ? ea_r[0] : pad_r[cur_r][0];
    assign dst_hi   = dir ? pad_r[cur_r][0] : ea_r[0];
    assign src_data = dir ? i_ram_rdata : i_per_rdata;

    ecd_lane u_lane (
        .i_byte   (cur_ctl[ecd_pkg::BIT_SIZE]),
        .i_src_hi (src_hi),
        .i_dst_hi (dst_hi),
        .i_data   (src_data),
        .o_data   (ln_data),
        .o_be     (ln_be)
    );

    // a cpu write to the very word the engine writes in the same cycle
    logic x_ev;
    logic p_ev;
    assign x_ev = (state_r == ecd_pkg::ST_WR) && o_ram_we && i_cpu_ram_we && (i_cpu_ram_addr == o_ram_addr);
    assign p_ev = (state_r == ecd_pkg::ST_WR) && o_per_we && i_cpu_per_we && (i_cpu_per_addr == o_per_addr);

    // software-owned channel registers; hardware only drops enable
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            for (int c = 0; c < ecd_pkg::NCH; c++) begin
                ctl_r[c] <= ecd_pkg::RST_REG;
                sel_r[c] <= ecd_pkg::RST_SEL;
                sta_r[c] <= ecd_pkg::RST_REG;
                stb_r[c] <= ecd_pkg::RST_REG;
                pad_r[c] <= ecd_pkg::RST_REG;
                cnt_r[c] <= ecd_pkg::RST_CNT;
            end
        end else if (i_clk_en) begin
            for (int c = 0; c < ecd_pkg::NCH; c++) begin
                if (hit(3'(c), ecd_pkg::OFS_CTL)) begin
                    ctl_r[c] <= i_wdata & ecd_pkg::CTL_MASK;
                end else if (bk && (cur_r == 3'(c)) && stop_now) begin
                    ctl_r[c][ecd_pkg::BIT_CHEN] <= 1'b0;
                end
                if (hit(3'(c), ecd_pkg::OFS_REQ)) begin
                    sel_r[c] <= i_wdata[6:0];
                end
                if (hit(3'(c), ecd_pkg::OFS_STA)) begin
                    sta_r[c] <= i_wdata;
                end
                if (hit(3'(c), ecd_pkg::OFS_STB)) begin
                    stb_r[c] <= i_wdata;
                end
                if (hit(3'(c), ecd_pkg::OFS_PAD)) begin
                    pad_r[c] <= i_wdata;
                end
                if (hit(3'(c), ecd_pkg::OFS_CNT)) begin
                    cnt_r[c] <= i_wdata[9:0];
                end
            end
        end
    end

    // live pointer, progress and ping-pong side; reloaded when a channel is enabled
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            for (int c = 0; c < ecd_pkg::NCH; c++) begin
                ptr_r[c]  <= ecd_pkg::RST_REG;
                done_r[c] <= ecd_pkg::RST_CNT;
            end
            pps_r <= 8'h00;
        end else if (i_clk_en) begin
            for (int c = 0; c < ecd_pkg::NCH; c++) begin
                if (hit(3'(c), ecd_pkg::OFS_CTL) && i_wdata[ecd_pkg::BIT_CHEN] && !chen_v[c]) begin
                    ptr_r[c]  <= sta_r[c];
                    done_r[c] <= ecd_pkg::RST_CNT;
                    pps_r[c]  <= 1'b0;
                end else if (bk && (cur_r == 3'(c))) begin
                    if (is_last) begin
                        done_r[c] <= ecd_pkg::RST_CNT;
                        pps_r[c]  <= cur_pps ^ pp_on;
                        ptr_r[c]  <= (pp_on && !cur_pps) ? stb_r[c] : sta_r[c];
                    end else begin
                        done_r[c] <= cur_done + 10'h001;
                        if (cur_am == ecd_pkg::AM_INC) begin
                            ptr_r[c] <= ecd_pkg::ecd_step(ptr_r[c], cur_ctl[ecd_pkg::BIT_SIZE]);
                        end
                    end
                end
            end
        end
    end

    // pending, force and collision flags: a set in the clearing cycle wins
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            pend_r  <= 8'h00;
            force_r <= 8'h00;
            xcol_r  <= 8'h00;
            pcol_r  <= 8'h00;
        end else if (i_clk_en) begin
            pend_r  <= (pend_r & ~g_clr) | trig_v;
            force_r <= (force_r & ~(bk ? cur_oh : 8'h00)) | force_set;
            xcol_r  <= (xcol_r & ~(wr_coll ? ~i_wdata[7:0] : 8'h00)) | (x_ev ? cur_oh : 8'h00);
            pcol_r  <= (pcol_r & ~(wr_coll ? ~i_wdata[15:8] : 8'h00)) | (p_ev ? cur_oh : 8'h00);
        end
    end

    // transfer engine: read, capture, write, on its own ports apart from the cpu
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            state_r     <= ecd_pkg::ST_IDLE;
            cur_r       <= 3'h0;
            ea_r        <= ecd_pkg::RST_REG;
            act_r       <= ecd_pkg::RST_IDLE_CH;
            o_ram_addr  <= 16'h0000;
            o_ram_wdata <= 16'h0000;
            o_ram_be    <= 2'h0;
            o_ram_we    <= 1'b0;
            o_ram_re    <= 1'b0;
            o_per_addr  <= 16'h0000;
            o_per_wdata <= 16'h0000;
            o_per_be    <= 2'h0;
            o_per_we    <= 1'b0;
            o_per_re    <= 1'b0;
            o_ch_irq    <= 8'h00;
        end else if (i_clk_en) begin
            o_ch_irq <= (bk && irq_hit) ? cur_oh : 8'h00;
            case (state_r)
                ecd_pkg::ST_IDLE: begin
                    act_r <= ecd_pkg::RST_IDLE_CH;
                    if (take) begin
                        state_r <= ecd_pkg::ST_RD;
                        cur_r   <= g_idx;
                        act_r   <= {1'b0, g_idx};
                        ea_r    <= g_ea;
                        if (g_ctl[ecd_pkg::BIT_DIR]) begin
                            o_ram_re   <= 1'b1;
                            o_ram_addr <= g_ea;
                        end else begin
                            o_per_re   <= 1'b1;
                            o_per_addr <= pad_r[g_idx];
                        end
                    end
                end
                ecd_pkg::ST_RD: begin
                    o_ram_re <= 1'b0;
                    o_per_re <= 1'b0;
                    state_r  <= ecd_pkg::ST_CAP;
                end
                ecd_pkg::ST_CAP: begin
                    state_r <= ecd_pkg::ST_WR;
                    if (dir) begin
                        o_per_we    <= 1'b1;
                        o_per_addr  <= pad_r[cur_r];
                        o_per_wdata <= ln_data;
                        o_per_be    <= ln_be;
                    end else begin
                        o_ram_we    <= 1'b1;
                        o_ram_addr  <= ea_r;
                        o_ram_wdata <= ln_data;
                        o_ram_be    <= ln_be;
                        // null write also pokes the peripheral with zero
                        if (cur_ctl[ecd_pkg::BIT_NULLW]) begin
                            o_per_we    <= 1'b1;
                            o_per_addr  <= pad_r[cur_r];
                            o_per_wdata <= 16'h0000;
                            o_per_be    <= 2'h3;
                        end
                    end
                end
                default: begin
                    o_ram_we <= 1'b0;
                    o_per_we <= 1'b0;
                    state_r  <= ecd_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // read decode; start registers show the live pointer
    logic [15:0] rd_val;
    always_comb begin
        rd_val = 16'h0000;
        if (is_ch && (reg_sel == ecd_pkg::OFS_CTL)) begin
            rd_val = ctl_r[ch_sel];
        end else if (is_ch && (reg_sel == ecd_pkg::OFS_REQ)) begin
            rd_val = {force_r[ch_sel], 8'h00, sel_r[ch_sel]};
        end else if (is_ch && ((reg_sel == ecd_pkg::OFS_STA) || (reg_sel == ecd_pkg::OFS_STB))) begin
            rd_val = ptr_r[ch_sel];
        end else if (is_ch && (reg_sel == ecd_pkg::OFS_PAD)) begin
            rd_val = pad_r[ch_sel];
        end else if (is_ch && (reg_sel == ecd_pkg::OFS_CNT)) begin
            rd_val = {6'h00, cnt_r[ch_sel]};
        end else if (i_addr == ecd_pkg::OFS_COLL) begin
            rd_val = {pcol_r, xcol_r};
        end else if (i_addr == ecd_pkg::OFS_PPS) begin
            rd_val = {4'h0, act_r, pps_r};
        end
    end

    // read data stand only in the cycle after the strobe
    always_ff @(posedge i_clock) begin
        if (i_sys_rst) begin
            o_rdata <= 16'h0000;
        end else if (i_clk_en) begin
            o_rdata <= i_rd ? rd_val : 16'h0000;
        end
    end

    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_sys_rst);

    a_fixed_prio: assert property (g_valid |-> ((arb_req & ((8'h01 << g_idx) - 8'h01)) == 8'h00))
        else $error("lower pending channel skipped");
    a_grant_valid: assert property (g_valid |-> arb_req[g_idx])
        else $error("grant to idle channel");
    a_rd_to_cap: assert property (state_r == ecd_pkg::ST_RD && i_clk_en |=> state_r == ecd_pkg::ST_CAP)
        else $error("engine skipped capture");
    a_ram_rd_dir: assert property (o_ram_re |-> dir && !o_ram_we)
        else $error("ram read against direction");
    a_per_wr_dir: assert property (o_per_we |-> dir || cur_ctl[ecd_pkg::BIT_NULLW])
        else $error("peripheral write against direction");
    a_ram_wr_dir: assert property (o_ram_we |-> !dir && (o_ram_addr == ea_r))
        else $error("ram write against direction");
    a_block_len: assert property (state_r != ecd_pkg::ST_IDLE |-> cur_done <= cur_cnt)
        else $error("block ran past count");
    a_coll_sticky: assert property ((|($past(xcol_r) & ~xcol_r)) |-> $past(wr_coll))
        else $error("collision flag fell without a write");
    a_force_clear: assert property ((|($past(force_r) & ~force_r)) |-> $past(state_r) == ecd_pkg::ST_CAP)
        else $error("force cleared outside a transfer");
    a_irq_cause: assert property ((|o_ch_irq) |-> $past(state_r) == ecd_pkg::ST_CAP ##1 o_ch_irq == 8'h00)
        else $error("interrupt without a block event");
    a_ptr_hold: assert property (state_r == ecd_pkg::ST_WR && $past(cur_am) == ecd_pkg::AM_HOLD && !$past(is_last)
        |-> ptr_r[cur_r] == $past(ptr_r[cur_r]))
        else $error("held pointer moved");

    c_block_end: cover property (bk && is_last);
    c_pingpong: cover property (bk && is_last && pp_on && cur_pps);
    c_collision: cover property (x_ev || p_ev);
    c_known_src: cover property (take && ((sel_r[g_idx] == ecd_pkg::RQ_ADC && pad_r[g_idx] == ecd_pkg::PA_ADC)
        || (sel_r[g_idx] == ecd_pkg::RQ_OC1 && (pad_r[g_idx] == ecd_pkg::PA_OC1_DATA
        || pad_r[g_idx] == ecd_pkg::PA_OC1_SEC)) || (sel_r[g_idx] == ecd_pkg::RQ_SPI1
        && pad_r[g_idx] == ecd_pkg::PA_SPI1)));
endmodule : ecd_controller
`default_nettype wire

// [verilog/ecd_lane.sv]
// ecd_lane: byte lane steering between source and destination
// assumes word transfers use even addresses; odd word addresses are not split
`default_nettype none
module ecd_lane (
    input  wire logic        i_byte,
    input  wire logic        i_src_hi,
    input  wire logic        i_dst_hi,
    input  wire logic [15:0] i_data,
    output logic      [15:0] o_data,
    output logic      [1:0]  o_be
);
    logic [7:0] pick;

    // byte mode moves one lane, picked by address bit 0 on each side
    assign pick   = i_src_hi ? i_data[15:8] : i_data[7:0];
    assign o_data = !i_byte ? i_data : (i_dst_hi ? {pick, 8'h00} : {8'h00, pick});
    assign o_be   = !i_byte ? 2'h3 : (i_dst_hi ? 2'h2 : 2'h1);
endmodule : ecd_lane
`default_nettype wire
